// *** cps_pkg.sv ***
// Constants and types shared by the capacitive sense control block.
package cps_pkg;

    // ********************************************************
    // Register map, byte offsets on the Wishbone bus
    // ********************************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CHAN_OFFSET = 8'h04;
    localparam logic [7:0] TIMER_CFG_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic TIMER_CFG_RESET = 1'b0;

    // ********************************************************
    // Field positions of the control register
    // ********************************************************
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_REF_MODE_BIT = 6;
    localparam int CTRL_RANGE_LSB = 2;
    localparam int CTRL_DIRECTION_BIT = 1;
    localparam int CTRL_EXT_SEL_BIT = 0;

    // Field positions of the channel and timer configuration registers.
    localparam int CHAN_FIELD_LSB = 0;
    localparam int TIMER_CFG_SEL_BIT = 0;

    // ********************************************************
    // Channels and timing
    // ********************************************************
    localparam int CHANNEL_COUNT = 12;
    localparam int SMALL_CHANNEL_COUNT = 8;
    localparam logic [1:0] FOSC_DIVIDE_LAST = 2'h3;

    // Current delivered to the sense pad.
    typedef enum logic [1:0] {
        CUR_NONE,
        CUR_LOW,
        CUR_MEDIUM,
        CUR_HIGH
    } current_level_t;

    // Clock feeding the 8-bit timer.
    typedef enum logic [1:0] {
        SRC_FOSC_QUARTER,
        SRC_TIMER_PIN,
        SRC_SENSE_OSC
    } timer_source_t;

endpackage : cps_pkg

// *** timer_clock_route.sv ***
// Timer clock routing: quarter-rate divider, edge detect and source mux.
`timescale 1ns/1ps
module timer_clock_route (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Source selection
    input cps_pkg::timer_source_t timerSource,
    // Candidate clocks, synchronous levels
    input wire logic senseOscLevel,
    input wire logic timerPinLevel,
    // One-cycle count pulse towards the timer
    output logic timerTick
);

    logic [1:0] foscCount;
    logic oscPrev;
    logic pinPrev;

    // ********************************************************
    // Quarter-rate tick
    // ********************************************************

    // Free-running divider, so the quarter-rate phase never depends on
    // when software switches sources.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            foscCount <= 2'h0;
        end else begin
            foscCount <= foscCount + 2'h1;
        end
    end

    // Previous levels of the external clocks for rising-edge detection.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscPrev <= 1'b0;
            pinPrev <= 1'b0;
        end else begin
            oscPrev <= senseOscLevel;
            pinPrev <= timerPinLevel;
        end
    end

    // ********************************************************
    // Source multiplexer
    // ********************************************************

    // One pulse per rising edge of the chosen source.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timerTick <= 1'b0;
        end else begin
            unique case (timerSource)
                cps_pkg::SRC_SENSE_OSC: begin
                    timerTick <= senseOscLevel & ~oscPrev;
                end
                cps_pkg::SRC_TIMER_PIN: begin
                    timerTick <= timerPinLevel & ~pinPrev;
                end
                cps_pkg::SRC_FOSC_QUARTER: begin
                    timerTick <=
                        (foscCount == cps_pkg::FOSC_DIVIDE_LAST);
                end
                default: begin
                    timerTick <= 1'b0;
                end
            endcase
        end
    end

endmodule : timer_clock_route

// *** capsense_osc_ctrl.sv ***
// Capacitive sense oscillator control with a Wishbone register slave.
//
// Overview of operation
// - Direction status bit reads 1 when sourcing current, 0 when sinking.
// - External source select acts only while timer clock select is 1.
// - Clock select 1, source select 1: timer counts sense oscillator.
// - Clock select 1, source select 0: timer counts its external pin.
// - Clock select 0: source select ignored, timer runs at quarter rate.
// - Unimplemented bits of the sense control registers read as zero.
`timescale 1ns/1ps
module capsense_osc_ctrl #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog oscillator interface
    input wire logic senseOscLevel,
    output logic oscEnable,
    output logic noiseDetect,
    output logic referenceVariable,
    output cps_pkg::current_level_t currentLevel,
    output logic [11:0] channelConnect,
    // Timer clocking
    input wire logic timerPinLevel,
    output logic timerTick
);

    // ********************************************************
    // Declarations
    // ********************************************************

    logic senseModuleEnable;
    logic referenceModeSelect;
    logic [1:0] currentRangeField;
    logic oscillatorDirectionFlag;
    logic timerExternalSourceSelect;
    logic [3:0] senseChannelField;
    logic timerClockSourceSelect;
    cps_pkg::timer_source_t timerSource;
    logic busWrite;
    logic busStart;
    logic [7:0] byteIn;
    logic [31:0] next_readData;

    // A channel code is usable only if it names a channel present on
    // this variant; the smaller part drops the upper channels.
    function automatic logic channelPresent(input logic [3:0] code);
        logic present;
        present = 1'b0;
        if (LARGE_VARIANT) begin
            present = (code < 4'(cps_pkg::CHANNEL_COUNT));
        end else begin
            present = (code < 4'(cps_pkg::SMALL_CHANNEL_COUNT));
        end
        return present;
    endfunction : channelPresent

    // Whether a given pad is connected for a code and enable state.
    function automatic logic channelHit(input logic enable,
                                        input logic [3:0] code,
                                        input int index);
        logic hit;
        hit = 1'b0;
        if (enable && channelPresent(code)) begin
            hit = (code == 4'(index));
        end
        return hit;
    endfunction : channelHit

    // ********************************************************
    // Wishbone handshake
    // ********************************************************

    // A request is seen in the cycle after the master raises it; the
    // write lands on the edge where the master samples ack.
    assign busStart = cyc_i & stb_i & ~ack_o;
    assign busWrite = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign byteIn = dat_i[7:0];

    // Ack lasts one cycle; a request still held after it is answered again after one idle cycle.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= busStart;
        end
    end

    // Read data is captured with ack and held steady until the next read.
    always_comb begin
        next_readData = 32'h0000_0000;
        unique case (adr_i)
            cps_pkg::CTRL_OFFSET: begin
                // Bits 5 and 4 and the upper lanes stay zero.
                next_readData[cps_pkg::CTRL_ENABLE_BIT] = senseModuleEnable;
                next_readData[cps_pkg::CTRL_REF_MODE_BIT] =
                    referenceModeSelect;
                next_readData[cps_pkg::CTRL_RANGE_LSB +: 2] =
                    currentRangeField;
                next_readData[cps_pkg::CTRL_DIRECTION_BIT] =
                    oscillatorDirectionFlag;
                next_readData[cps_pkg::CTRL_EXT_SEL_BIT] =
                    timerExternalSourceSelect;
            end
            cps_pkg::CHAN_OFFSET: begin
                next_readData[cps_pkg::CHAN_FIELD_LSB +: 4] =
                    senseChannelField;
            end
            cps_pkg::TIMER_CFG_OFFSET: begin
                next_readData[cps_pkg::TIMER_CFG_SEL_BIT] =
                    timerClockSourceSelect;
            end
            cps_pkg::STATUS_OFFSET: begin
                next_readData[0] = oscEnable;
                next_readData[2:1] = currentLevel;
                next_readData[3] = noiseDetect;
                next_readData[4] = |channelConnect;
                next_readData[6:5] = timerSource;
            end
            default: begin
                // Unmapped addresses still ack and read zero.
                next_readData = 32'h0000_0000;
            end
        endcase
    end

    // Read data register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dat_o <= 32'h0000_0000;
        end else if (busStart && !we_i) begin
            dat_o <= next_readData;
        end
    end

    // ********************************************************
    // Software registers
    // ********************************************************

    // Control register; the direction flag is not writable.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            senseModuleEnable <= cps_pkg::CTRL_RESET[cps_pkg::CTRL_ENABLE_BIT];
            referenceModeSelect <=
                cps_pkg::CTRL_RESET[cps_pkg::CTRL_REF_MODE_BIT];
            currentRangeField <=
                cps_pkg::CTRL_RESET[cps_pkg::CTRL_RANGE_LSB +: 2];
            timerExternalSourceSelect <=
                cps_pkg::CTRL_RESET[cps_pkg::CTRL_EXT_SEL_BIT];
        end else if (busWrite && adr_i == cps_pkg::CTRL_OFFSET) begin
            senseModuleEnable <= byteIn[cps_pkg::CTRL_ENABLE_BIT];
            referenceModeSelect <= byteIn[cps_pkg::CTRL_REF_MODE_BIT];
            currentRangeField <= byteIn[cps_pkg::CTRL_RANGE_LSB +: 2];
            timerExternalSourceSelect <= byteIn[cps_pkg::CTRL_EXT_SEL_BIT];
        end
    end

    // Channel field; the code is stored as written even if it names a
    // missing channel, and the decode below keeps such codes inert.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            senseChannelField <= cps_pkg::CHAN_RESET;
        end else if (busWrite && adr_i == cps_pkg::CHAN_OFFSET) begin
            senseChannelField <= byteIn[cps_pkg::CHAN_FIELD_LSB +: 4];
        end
    end

    // Timer clock select, held here since the timer is outside the block.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timerClockSourceSelect <= cps_pkg::TIMER_CFG_RESET;
        end else if (busWrite && adr_i == cps_pkg::TIMER_CFG_OFFSET) begin
            timerClockSourceSelect <= byteIn[cps_pkg::TIMER_CFG_SEL_BIT];
        end
    end

    // ********************************************************
    // Oscillator status
    // ********************************************************

    // The oscillator output high means the pad is being charged, so the
    // level is the direction of current flow.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscillatorDirectionFlag <= 1'b0;
        end else begin
            oscillatorDirectionFlag <= senseOscLevel;
        end
    end

    // ********************************************************
    // Current range decode
    // ********************************************************

    // Disabling the module stops the oscillator whatever the range says.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscEnable <= 1'b0;
            noiseDetect <= 1'b0;
            referenceVariable <= 1'b0;
            currentLevel <= cps_pkg::CUR_NONE;
        end else if (!senseModuleEnable) begin
            oscEnable <= 1'b0;
            noiseDetect <= 1'b0;
            referenceVariable <= referenceModeSelect;
            currentLevel <= cps_pkg::CUR_NONE;
        end else if (referenceModeSelect) begin
            // Code 00 keeps the oscillator running for noise sampling.
            oscEnable <= 1'b1;
            noiseDetect <= (currentRangeField == 2'h0);
            referenceVariable <= 1'b1;
            currentLevel <=
                cps_pkg::current_level_t'(currentRangeField);
        end else begin
            oscEnable <= (currentRangeField != 2'h0);
            noiseDetect <= 1'b0;
            referenceVariable <= 1'b0;
            currentLevel <=
                cps_pkg::current_level_t'(currentRangeField);
        end
    end

    // ********************************************************
    // Channel multiplexer
    // ********************************************************

    // One registered connect line per pad; at most one is ever high.
    for (genvar ch = 0; ch < cps_pkg::CHANNEL_COUNT; ch++) begin : g_chan
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                channelConnect[ch] <= 1'b0;
            end else begin
                channelConnect[ch] <=
                    channelHit(senseModuleEnable, senseChannelField, ch);
            end
        end
    end

    // ********************************************************
    // Timer clock routing
    // ********************************************************

    // The external source select is only consulted once the timer has
    // been pointed at an external clock.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timerSource <= cps_pkg::SRC_FOSC_QUARTER;
        end else if (!timerClockSourceSelect) begin
            timerSource <= cps_pkg::SRC_FOSC_QUARTER;
        end else if (timerExternalSourceSelect) begin
            timerSource <= cps_pkg::SRC_SENSE_OSC;
        end else begin
            timerSource <= cps_pkg::SRC_TIMER_PIN;
        end
    end

    // Edge detection and division live in the routing leaf.
    timer_clock_route i_timer_clock_route (
        .clk(clk),
        .sys_rst(sys_rst),
        .timerSource(timerSource),
        .senseOscLevel(senseOscLevel),
        .timerPinLevel(timerPinLevel),
        .timerTick(timerTick)
    );

endmodule : capsense_osc_ctrl

// *** capsense_osc_ctrl_props.sv ***
// Port-level assertions for the capacitive sense control block.
`timescale 1ns/1ps
module capsense_osc_ctrl_props #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Oscillator and timer
    input wire logic senseOscLevel,
    input wire logic oscEnable,
    input wire logic noiseDetect,
    input wire logic referenceVariable,
    input wire cps_pkg::current_level_t currentLevel,
    input wire logic [11:0] channelConnect,
    input wire logic timerTick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Bus handshake: one answer per request, one cycle long.
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    // Noise detect runs the oscillator with no current at all.
    noise_mode_a: assert property (noiseDetect |-> oscEnable &&
        referenceVariable && currentLevel == cps_pkg::CUR_NONE)
        else $error("noise mode wrong");
    // A running oscillator outside noise detect always has a range.
    range_on_a: assert property (oscEnable && !noiseDetect |->
        currentLevel != cps_pkg::CUR_NONE) else $error("no range");
    // The direction bit shows the pad level of one cycle before the read.
    dir_read_a: assert property (ack_o && $past(cyc_i && !we_i &&
        adr_i == cps_pkg::CTRL_OFFSET) |-> dat_o[1] ==
        $past(senseOscLevel, 2)) else $error("direction bit wrong");
    unused_zero_a: assert property (ack_o && !we_i |->
        dat_o[31:8] == 24'h0 && (adr_i != cps_pkg::CTRL_OFFSET ||
        dat_o[5:4] == 2'h0) && (adr_i != cps_pkg::CHAN_OFFSET ||
        dat_o[7:4] == 4'h0)) else $error("unused bits not zero");
    chan_onehot_a: assert property ($onehot0(channelConnect))
        else $error("several pads connected");
    chan_upper_a: assert property (channelConnect[11:8] != 4'h0 |->
        LARGE_VARIANT) else $error("upper pad on small variant");
    tick_pulse_a: assert property (timerTick |=> !timerTick)
        else $error("tick longer than one cycle");
endmodule : capsense_osc_ctrl_props

bind capsense_osc_ctrl capsense_osc_ctrl_props #(
    .LARGE_VARIANT(LARGE_VARIANT)
) i_capsense_osc_ctrl_props (.clk(clk), .sys_rst(sys_rst),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .senseOscLevel(senseOscLevel),
    .oscEnable(oscEnable), .noiseDetect(noiseDetect),
    .referenceVariable(referenceVariable), .currentLevel(currentLevel),
    .channelConnect(channelConnect), .timerTick(timerTick));

// *** sense_pad_model.sv ***
// Behavioural sense pad seen as a relaxation oscillator level.
`timescale 1ns/1ps
module sense_pad_model #(
    parameter int HALF = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pad side
    input wire logic oscEnable,
    output logic senseOscLevel
);
    int cnt;

    // The level swings only while enabled; a stopped pad keeps its charge,
    // so the last level stays put.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            senseOscLevel <= 1'b0;
        end else if (oscEnable) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) senseOscLevel <= !senseOscLevel;
        end
    end
endmodule : sense_pad_model

// *** tb_capsense_osc_ctrl.sv ***
// Self-checking testbench for the capacitive sense control block.
`timescale 1ns/1ps
module tb_capsense_osc_ctrl;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0, datR, rng = 32'h0000dbee;
    logic ack, osc, oscEn, noise, refVar, tick, oscPrev = 1'b0;
    logic [11:0] chan;
    cps_pkg::current_level_t cur;
    logic [31:0] expQ[$], maskQ[$];
    int error_cnt = 0, n_tests = 0, tickCnt = 0, riseCnt = 0;

    always #2.5 clk = ~clk;

    capsense_osc_ctrl #(.LARGE_VARIANT(1'b1)) i_capsense_osc_ctrl (
        .clk(clk), .sys_rst(sysRst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
        .senseOscLevel(osc), .oscEnable(oscEn), .noiseDetect(noise),
        .referenceVariable(refVar), .currentLevel(cur),
        .channelConnect(chan), .timerPinLevel(pin), .timerTick(tick));
    sense_pad_model i_sense_pad_model (.clk(clk), .sys_rst(sysRst),
        .oscEnable(oscEn), .senseOscLevel(osc));

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic check(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // Classic cycle: hold everything until ack is seen, then release.
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel} <= {1'b1, 1'b1, w, a, 4'h1};
        datW <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb, we} <= 3'b000;
    endtask : bus

    task rd(input logic [7:0] a, input logic [31:0] e, m);
        expQ.push_back(e);
        maskQ.push_back(m);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    // Monitor: pairs each read answer with the oldest note, counts ticks.
    always @(posedge clk) begin
        if (tick === 1'b1) tickCnt++;
        if (osc === 1'b1 && oscPrev === 1'b0) riseCnt++;
        oscPrev = osc;
        if (ack === 1'b1 && we === 1'b0) begin
            if (expQ.size() == 0) check("stray read", 32'h1, 32'h0);
            else check("read", datR & maskQ.pop_front(),
                expQ.pop_front());
        end
    end

    // Watchdog far beyond the expected run length.
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        logic [1:0] rr;
        logic on, nz;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        rd(cps_pkg::CTRL_OFFSET, 32'h0, '1);
        rd(cps_pkg::CHAN_OFFSET, 32'h0, '1);
        rd(cps_pkg::TIMER_CFG_OFFSET, 32'h0, '1);
        rd(cps_pkg::STATUS_OFFSET, 32'h0, '1);
        bus(1'b1, 8'h10, 8'hff);
        rd(8'h10, 32'h0, '1);
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'hff);
        rd(cps_pkg::CTRL_OFFSET, 32'hcd, 32'hfffffffd);
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h00);
        settle(3);
        rd(cps_pkg::CTRL_OFFSET, {30'h0, osc, 1'b0}, '1);
        // Every reference mode with every range code.
        bus(1'b1, cps_pkg::CHAN_OFFSET, 8'h03);
        for (int m = 0; m < 2; m++) begin
            for (int r = 0; r < 4; r++) begin
                rr = 2'(r);
                nz = (m == 1 && r == 0);
                on = !(m == 0 && r == 0);
                bus(1'b1, cps_pkg::CTRL_OFFSET,
                    8'h80 | 8'(m << 6) | 8'(r << 2));
                settle(3);
                check("level", {30'h0, cur}, {30'h0, rr});
                check("noise", {31'h0, noise}, {31'h0, nz});
                check("osc on", {31'h0, oscEn}, {31'h0, on});
                check("ref mode", {31'h0, refVar}, 32'(m));
                rd(cps_pkg::STATUS_OFFSET, {27'h0, 1'b1, nz, rr, on},
                    32'h1f);
            end
        end
        // Every channel code while enabled, then code 5 while disabled.
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, cps_pkg::CHAN_OFFSET, 8'(c));
            settle(3);
            check("pad", {20'h0, chan}, (c < 12) ? 32'h1 << c : 32'h0);
        end
        bus(1'b1, cps_pkg::CHAN_OFFSET, 8'h05);
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h00);
        settle(3);
        check("pad off", {20'h0, chan}, 32'h0);
        repeat (8) begin
            rng = xs(rng);
            bus(1'b1, cps_pkg::CHAN_OFFSET, rng[7:0]);
            rd(cps_pkg::CHAN_OFFSET, {28'h0, rng[3:0]}, '1);
        end
        // Timer source for each select pair.
        for (int t = 0; t < 2; t++) begin
            for (int x = 0; x < 2; x++) begin
                bus(1'b1, cps_pkg::TIMER_CFG_OFFSET, 8'(t));
                bus(1'b1, cps_pkg::CTRL_OFFSET, 8'(x));
                settle(3);
                rd(cps_pkg::STATUS_OFFSET, 32'((t == 0) ? 0 : (x == 1) ? 2 : 1)
                    << 5, 32'h60);
            end
        end
        // Quarter rate ignores the source select, pad and pin activity.
        bus(1'b1, cps_pkg::TIMER_CFG_OFFSET, 8'h00);
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h8d);
        settle(3);
        @(negedge clk) tickCnt = 0;
        repeat (40) @(posedge clk) begin
            rng = xs(rng);
            pin <= rng[0];
        end
        @(negedge clk) check("quarter", 32'(tickCnt), 32'd10);
        // Pin source with the pad stopped.
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h00);
        bus(1'b1, cps_pkg::TIMER_CFG_OFFSET, 8'h01);
        pin <= 1'b0;
        settle(4);
        @(negedge clk) tickCnt = 0;
        repeat (5) begin
            @(posedge clk) pin <= 1'b1;
            repeat (3) @(posedge clk) pin <= 1'b0;
        end
        settle(4);
        @(negedge clk) check("pin ticks", 32'(tickCnt), 32'd5);
        // Pad oscillator source while the pin keeps toggling.
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h01);
        settle(4);
        @(negedge clk) begin
            tickCnt = 0;
            riseCnt = 0;
        end
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h85);
        repeat (30) @(posedge clk) begin
            rng = xs(rng);
            pin <= rng[0];
        end
        bus(1'b1, cps_pkg::CTRL_OFFSET, 8'h01);
        settle(6);
        @(negedge clk) check("osc ticks", 32'(tickCnt), 32'(riseCnt));
        check("osc ran", {31'h0, riseCnt > 3}, 32'h1);
        final_report();
    end
endmodule : tb_capsense_osc_ctrl
